// ---- rtl/ucp_pkg.sv ----
// Purpose: constants for the control pipe configuration block
// Assumes: 16-bit register port, byte offsets as printed
// Notes: shared by the tracker, the pipe configuration block and the bench; the event interface does not import it
package ucp_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] UCP_ADDR_CONFIG = 8'h5c;
   localparam logic [7:0] UCP_ADDR_MAXP = 8'h5e;
   localparam logic [7:0] UCP_ADDR_CTRL = 8'h60;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int UCP_CFG_CNTMODE = 8;
   localparam int UCP_CFG_NAKEND = 7;
   localparam int UCP_MAXP_W = 7;
   localparam int UCP_CTL_FIFOOK = 15;
   localparam int UCP_CTL_TCLR = 8;
   localparam int UCP_CTL_TSET = 7;
   localparam int UCP_CTL_TMON = 6;
   localparam int UCP_CTL_BUSY = 5;
   localparam int UCP_CTL_DONEEN = 2;
   localparam logic [6:0] UCP_MAXP_RESET = 7'h40;
   localparam logic UCP_TOGGLE_RESET = 1'h1;
   // ------------------------------------------------------------
   // Response select and tracker state codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      UCP_RSP_NAK = 2'h0,
      UCP_RSP_BUF = 2'h1,
      UCP_RSP_STALL = 2'h2,
      UCP_RSP_STALL3 = 2'h3
   } ucp_rsp_t;
   typedef enum logic [2:0] {
      UCP_ST_IDLE = 3'h1,
      UCP_ST_BUSY = 3'h2,
      UCP_ST_STATUS = 3'h4
   } ucp_state_t;
endpackage

// ---- rtl/ucp_evt_if.sv ----
// Purpose: USB-side event bundle between pipe logic and its tracker
// Assumes: events are one-cycle pulses
// Notes: none
interface ucp_evt_if;
   logic txn_start;
   logic txn_done;
   logic txn_status;
   logic pid_mismatch;
   logic setup_rx;
   logic busy;
   logic in_status;
   modport src(output txn_start, txn_done, txn_status, pid_mismatch,
      setup_rx, input busy, in_status);
   modport trk(input txn_start, txn_done, txn_status, pid_mismatch,
      setup_rx, output busy, in_status);
endinterface

// ---- rtl/ucp_txn_track.sv ----
// Purpose: tracks whether a transaction of the pipe is on the bus
// Assumes: start and done pulses come from the packet engine
// Notes: status stage remembered until next start or setup
module ucp_txn_track
   import ucp_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   ucp_evt_if.trk ev
);
   ucp_state_t state_q;
   logic stat_q;
   // ------------------------------------------------------------
   // Busy state
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= UCP_ST_IDLE;
      end else begin
         case (state_q)
            UCP_ST_IDLE: begin
               if (ev.txn_start) begin
                  state_q <= ev.txn_status ? UCP_ST_STATUS : UCP_ST_BUSY;
               end
            end
            UCP_ST_BUSY, UCP_ST_STATUS: begin
               if (ev.txn_done || ev.setup_rx) begin
                  state_q <= UCP_ST_IDLE;
               end
            end
            default: begin
               state_q <= UCP_ST_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stat_q <= 1'h0;
      end else if (ev.setup_rx) begin
         stat_q <= 1'h0;
      end else if (ev.txn_start) begin
         stat_q <= ev.txn_status;
      end
   end
   assign ev.busy = (state_q != UCP_ST_IDLE);
   assign ev.in_status = stat_q;
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_busy_rise;
      @(posedge clk) disable iff (!nrst)
      (state_q == UCP_ST_IDLE && ev.txn_start) |=> ev.busy;
   endproperty
   a_busy_rise: assert property (p_busy_rise)
      else $error("busy did not rise on start");
   property p_busy_fall;
      @(posedge clk) disable iff (!nrst)
      (ev.busy && ev.txn_done) |=> !ev.busy;
   endproperty
   a_busy_fall: assert property (p_busy_fall)
      else $error("busy did not fall on done");
endmodule

// ---- rtl/ucp_pipe_cfg.sv ----
// Function
// - Control transfers use the dedicated default pipe
// - Config bit 8 selects continuous mode
// - Config bit 7 forces NAK at receive end
// - One continuous select serves both directions
// - Max packet bits 6-0, reset 64
// - Control bit 15 shows FIFO access ok
// - Writing bit 8 forces toggle DATA0
// - Writing bit 7 forces toggle DATA1
// - Bit 6 shows expected toggle, reset 1
// - Bit 5 shows pipe in use
// - Bit 2 enables status stage completion
// - Bits 1-0 select NAK, BUF or STALL
// - Setup forces NAK, valid, toggle DATA1, clears enable
// - Oversize under BUF or sequence error STALL; reset NAK
// - Toggle flips on good transaction outside status stage only
// - Busy rises on start, falls on done
//
// Purpose: configuration and control of the default control pipe
// Assumes: USB engine events are synchronous one-cycle pulses
// Notes: registers are 16 bits, read data one cycle after strobe
//
// The implementer's own choice: the strobed register port.
module ucp_pipe_cfg
   import ucp_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic TXN_START,
   input wire logic TXN_DONE,
   input wire logic TXN_STATUS,
   input wire logic TXN_RX,
   input wire logic PID_MISMATCH,
   input wire logic SETUP_RX,
   input wire logic OVERSIZE_RX,
   input wire logic SEQ_ERROR,
   input wire logic BUS_RESET,
   input wire logic FIFO_READY,
   input wire logic VALID_CLEAR,
   output logic [1:0] RESPONSE_SELECT,
   output logic CONTINUOUS_MODE_SEL,
   output logic [6:0] MAX_PAYLOAD_SIZE,
   output logic STATUS_STAGE_DONE_EN,
   output logic TOGGLE_EXPECTED,
   output logic PIPE_IN_USE,
   output logic SETUP_VALID
);
   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   logic wr_cfg;
   logic wr_maxp;
   logic wr_ctl;
   logic cont_q;
   logic nak_end_q;
   logic [6:0] maxp_q;
   logic [1:0] rsp_q;
   logic done_en_q;
   logic tog_q;
   logic valid_q;
   logic fifo_ok_q;
   logic busy_q;
   logic [15:0] rdata_q;
   logic [15:0] rd_d;

   ucp_evt_if ev();
   assign ev.txn_start = TXN_START;
   assign ev.txn_done = TXN_DONE;
   assign ev.txn_status = TXN_STATUS;
   assign ev.pid_mismatch = PID_MISMATCH;
   assign ev.setup_rx = SETUP_RX;

   ucp_txn_track u_trk (
      .clk(CLK),
      .nrst(NRST),
      .ev(ev)
   );

   assign wr_cfg = WR && hit(ADDR, UCP_ADDR_CONFIG);
   assign wr_maxp = WR && hit(ADDR, UCP_ADDR_MAXP);
   assign wr_ctl = WR && hit(ADDR, UCP_ADDR_CTRL);

   // ------------------------------------------------------------
   // Configuration register
   // ------------------------------------------------------------
   // A single mode bit; the pipe buffer is shared by both directions
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cont_q <= 1'h0;
         nak_end_q <= 1'h0;
      end else if (wr_cfg) begin
         cont_q <= WDATA[UCP_CFG_CNTMODE];
         nak_end_q <= WDATA[UCP_CFG_NAKEND];
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         maxp_q <= UCP_MAXP_RESET;
      end else if (wr_maxp) begin
         maxp_q <= WDATA[UCP_MAXP_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // Response select: hardware events win over software writes
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rsp_q <= UCP_RSP_NAK;
      end else if (BUS_RESET || SETUP_RX) begin
         rsp_q <= UCP_RSP_NAK;
      end else if ((OVERSIZE_RX && rsp_q == UCP_RSP_BUF) || SEQ_ERROR) begin
         rsp_q <= UCP_RSP_STALL3;
      end else if (TXN_DONE && TXN_RX && nak_end_q && !ev.in_status
                   && rsp_q == UCP_RSP_BUF) begin
         rsp_q <= UCP_RSP_NAK;
      end else if (wr_ctl && !valid_q) begin
         // Software cannot move it while a fresh setup is unread
         rsp_q <= WDATA[1:0];
      end
   end

   // Setup flag: a setup in the same cycle as the clear wins
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         valid_q <= 1'h0;
      end else if (SETUP_RX) begin
         valid_q <= 1'h1;
      end else if (VALID_CLEAR) begin
         valid_q <= 1'h0;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         done_en_q <= 1'h0;
      end else if (SETUP_RX) begin
         done_en_q <= 1'h0;
      end else if (wr_ctl && WDATA[UCP_CTL_DONEEN] && !valid_q) begin
         done_en_q <= 1'h1;
      end else if (TXN_DONE && ev.in_status) begin
         done_en_q <= 1'h0;
      end
   end

   // ------------------------------------------------------------
   // Sequence toggle
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tog_q <= UCP_TOGGLE_RESET;
      end else if (SETUP_RX) begin
         tog_q <= 1'h1;
      end else if (wr_ctl && WDATA[UCP_CTL_TCLR]) begin
         tog_q <= 1'h0;
      end else if (wr_ctl && WDATA[UCP_CTL_TSET]) begin
         tog_q <= 1'h1;
      end else if (TXN_DONE && !PID_MISMATCH && !ev.in_status) begin
         tog_q <= ~tog_q;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         fifo_ok_q <= 1'h0;
         busy_q <= 1'h0;
      end else begin
         fifo_ok_q <= FIFO_READY;
         busy_q <= ev.busy;
      end
   end

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_comb begin
      rd_d = 16'h0000;
      if (hit(ADDR, UCP_ADDR_CONFIG)) begin
         rd_d[UCP_CFG_CNTMODE] = cont_q;
         rd_d[UCP_CFG_NAKEND] = nak_end_q;
      end else if (hit(ADDR, UCP_ADDR_MAXP)) begin
         rd_d[UCP_MAXP_W-1:0] = maxp_q;
      end else if (hit(ADDR, UCP_ADDR_CTRL)) begin
         rd_d[UCP_CTL_FIFOOK] = fifo_ok_q;
         rd_d[UCP_CTL_TMON] = tog_q;
         rd_d[UCP_CTL_BUSY] = busy_q;
         rd_d[1:0] = rsp_q;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rdata_q <= 16'h0000;
      end else if (RD) begin
         rdata_q <= rd_d;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign RDATA = rdata_q;
   assign RESPONSE_SELECT = rsp_q;
   assign CONTINUOUS_MODE_SEL = cont_q;
   assign MAX_PAYLOAD_SIZE = maxp_q;
   assign STATUS_STAGE_DONE_EN = done_en_q;
   assign TOGGLE_EXPECTED = tog_q;
   assign PIPE_IN_USE = busy_q;
   assign SETUP_VALID = valid_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_setup;
      SETUP_RX;
   endsequence
   sequence s_setup_effect;
      rsp_q == UCP_RSP_NAK && valid_q && !done_en_q && tog_q;
   endsequence
   property p_setup;
      @(posedge CLK) disable iff (!NRST) s_setup |=> s_setup_effect;
   endproperty
   a_setup: assert property (p_setup)
      else $error("setup did not force pipe state");
   property p_reset_nak;
      @(posedge CLK) disable iff (!NRST)
      BUS_RESET |=> rsp_q == UCP_RSP_NAK;
   endproperty
   a_reset_nak: assert property (p_reset_nak)
      else $error("bus reset did not force NAK");
   property p_seq_stall;
      @(posedge CLK) disable iff (!NRST)
      (SEQ_ERROR && !SETUP_RX && !BUS_RESET) |=> rsp_q == UCP_RSP_STALL3;
   endproperty
   a_seq_stall: assert property (p_seq_stall)
      else $error("sequence error did not stall");
   property p_tclr;
      @(posedge CLK) disable iff (!NRST)
      (wr_ctl && WDATA[UCP_CTL_TCLR] && !SETUP_RX) |=> !tog_q;
   endproperty
   a_tclr: assert property (p_tclr)
      else $error("toggle clear failed");
   property p_tset;
      @(posedge CLK) disable iff (!NRST)
      (wr_ctl && WDATA[UCP_CTL_TSET] && !WDATA[UCP_CTL_TCLR]) |=> tog_q;
   endproperty
   a_tset: assert property (p_tset)
      else $error("toggle set failed");
   property p_toggle;
      @(posedge CLK) disable iff (!NRST)
      (TXN_DONE && !PID_MISMATCH && !ev.in_status && !SETUP_RX && !wr_ctl)
      |=> tog_q != $past(tog_q);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle did not flip");
   property p_mismatch;
      @(posedge CLK) disable iff (!NRST)
      (TXN_DONE && PID_MISMATCH && !SETUP_RX && !wr_ctl) |=> $stable(tog_q);
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("toggle flipped on mismatch");
   property p_rd_zero;
      @(posedge CLK) disable iff (!NRST)
      (RD && hit(ADDR, UCP_ADDR_MAXP)) |=> RDATA[15:UCP_MAXP_W] == 9'h000;
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("unassigned bits not zero");
   property p_busy_shown;
      @(posedge CLK) disable iff (!NRST) ev.busy |=> PIPE_IN_USE;
   endproperty
   a_busy_shown: assert property (p_busy_shown)
      else $error("busy not shown");
   property p_nak_end;
      @(posedge CLK) disable iff (!NRST)
      (TXN_DONE && TXN_RX && nak_end_q && !ev.in_status
         && rsp_q == UCP_RSP_BUF && !BUS_RESET && !SETUP_RX
         && !OVERSIZE_RX && !SEQ_ERROR) |=> rsp_q == UCP_RSP_NAK;
   endproperty
   a_nak_end: assert property (p_nak_end)
      else $error("receive end did not force NAK");
   property p_oversize;
      @(posedge CLK) disable iff (!NRST)
      (OVERSIZE_RX && rsp_q == UCP_RSP_BUF && !BUS_RESET && !SETUP_RX)
      |=> rsp_q == UCP_RSP_STALL3;
   endproperty
   a_oversize: assert property (p_oversize)
      else $error("oversize did not stall");
   property p_done_clr;
      @(posedge CLK) disable iff (!NRST)
      (TXN_DONE && ev.in_status && !(wr_ctl && WDATA[UCP_CTL_DONEEN]))
      |=> !done_en_q;
   endproperty
   a_done_clr: assert property (p_done_clr)
      else $error("status end did not clear enable");
   // Software is locked out of the response while a setup is unread
   property p_sw_locked;
      @(posedge CLK) disable iff (!NRST)
      (valid_q && !SETUP_RX && !BUS_RESET && !SEQ_ERROR && !OVERSIZE_RX
         && !TXN_DONE) |=> $stable(rsp_q);
   endproperty
   a_sw_locked: assert property (p_sw_locked)
      else $error("response moved while setup unread");
endmodule

// ---- verification/ucp_host_model.sv ----
// Purpose: host-side packet engine stand-in for the control pipe
// Assumes: events are one-cycle pulses launched after a rising edge
// Notes: qualifiers wander randomly outside their strobes
module ucp_host_model (
   input wire logic clk,
   output logic txn_start,
   output logic txn_done,
   output logic txn_status,
   output logic txn_rx,
   output logic pid_mismatch,
   output logic fifo_ready,
   output logic [4:0] ev
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {txn_start, txn_done, txn_status, txn_rx, pid_mismatch} = '0;
      fifo_ready = 1'b0;
      ev = '0;
   end
   // Stage flag only means something beside the start strobe
   task automatic start(input logic st);
      @(posedge clk);
      txn_start <= 1'b1;
      txn_status <= st;
      @(posedge clk);
      txn_start <= 1'b0;
      txn_status <= 1'($urandom);
   endtask
   task automatic finish(input logic st, input logic rx, input logic mm);
      @(posedge clk);
      txn_done <= 1'b1;
      txn_status <= st;
      txn_rx <= rx;
      pid_mismatch <= mm;
      @(posedge clk);
      txn_done <= 1'b0;
      txn_status <= 1'($urandom);
      txn_rx <= 1'($urandom);
      pid_mismatch <= 1'($urandom);
   endtask
   // 0 setup, 1 oversize, 2 sequence error, 3 bus reset, 4 valid clear
   task automatic pulse(input int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev <= '0;
   endtask
   task automatic set_fifo(input logic v);
      @(posedge clk);
      fifo_ready <= v;
   endtask
endmodule

// ---- verification/usb_control_pipe_config_bench.sv ----
// Purpose: self-checking bench for the control pipe registers
// Assumes: read data valid only in the cycle after the read strobe
// Notes: buffer access flag random in the first loop, held at 1 afterwards
module usb_control_pipe_config_bench;
   import ucp_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = '0;
   logic [15:0] wdata = '0, rdata, d;
   logic wr = 1'b0, rd = 1'b0;
   logic st, rx, mm, tg, cm, f;
   logic [7:0] ua;
   logic [1:0] rsel;
   logic [6:0] maxp;
   logic tstart, tdone, tstat, trx, tmm, fifo, done_en, tog, busy, valid;
   logic [4:0] ev;
   int num_errors = 0, n_tests = 0;
   always #2 clk = ~clk;
   ucp_host_model host (.clk(clk), .txn_start(tstart), .txn_done(tdone),
      .txn_status(tstat), .txn_rx(trx), .pid_mismatch(tmm),
      .fifo_ready(fifo), .ev(ev));
   ucp_pipe_cfg DUT (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .TXN_START(tstart),
      .TXN_DONE(tdone), .TXN_STATUS(tstat), .TXN_RX(trx),
      .PID_MISMATCH(tmm), .SETUP_RX(ev[0]), .OVERSIZE_RX(ev[1]),
      .SEQ_ERROR(ev[2]), .BUS_RESET(ev[3]), .FIFO_READY(fifo),
      .VALID_CLEAR(ev[4]), .RESPONSE_SELECT(rsel),
      .CONTINUOUS_MODE_SEL(cm), .MAX_PAYLOAD_SIZE(maxp),
      .STATUS_STAGE_DONE_EN(done_en), .TOGGLE_EXPECTED(tog),
      .PIPE_IN_USE(busy), .SETUP_VALID(valid));
   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] cw(logic t, logic b, logic [1:0] r);
      return {1'b1, 6'h0, 2'h0, t, b, 3'h0, r};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic final_report();
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      final_report();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'h6e8d));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rchk(UCP_ADDR_CONFIG, 16'h0000);
      rchk(UCP_ADDR_MAXP, 16'h0040);
      rchk(UCP_ADDR_CTRL, 16'h0040);
      rchk(8'h62, 16'h0000);
      host.set_fifo(1'b1);
      rchk(UCP_ADDR_CTRL, 16'h8040);
      wrr(8'h62, 16'hffff);
      rchk(8'h62, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         d = 16'($urandom);
         wrr(UCP_ADDR_CONFIG, d);
         // Odd addresses never decode, so a stray write must not land
         ua = 8'($urandom) | 8'h01;
         wrr(ua, 16'($urandom));
         rchk(ua, 16'h0000);
         rchk(UCP_ADDR_CONFIG, d & 16'h0180);
         f = 1'($urandom);
         host.set_fifo(f);
         rchk(UCP_ADDR_CTRL, {f, 15'h0040});
         chk(16'(cm), 16'(d[8]));
         // Legal control sizes only, never zero, and only under NAK
         d = 16'($urandom) & 16'hff80 | (16'h8 << ($urandom % 4));
         wrr(UCP_ADDR_MAXP, d);
         rchk(UCP_ADDR_MAXP, d & 16'h007f);
         chk(16'(maxp), d & 16'h007f);
      end
      host.set_fifo(1'b1);
      wrr(UCP_ADDR_CONFIG, 16'h0000);
      for (int i = 3; i >= 0; i--) begin
         wrr(UCP_ADDR_CTRL, 16'h7e18 | 16'(i));
         rchk(UCP_ADDR_CTRL, cw(1'b1, 1'b0, 2'(i)));
         chk(16'(rsel), 16'(i));
      end
      wrr(UCP_ADDR_CTRL, 16'h0100);
      rchk(UCP_ADDR_CTRL, cw(1'b0, 1'b0, 2'h0));
      wrr(UCP_ADDR_CTRL, 16'h0000);
      rchk(UCP_ADDR_CTRL, cw(1'b0, 1'b0, 2'h0));
      wrr(UCP_ADDR_CTRL, 16'h0080);
      rchk(UCP_ADDR_CTRL, cw(1'b1, 1'b0, 2'h0));
      tg = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rx = 1'($urandom);
         // A data PID mismatch can only arise on received data
         mm = rx & 1'($urandom);
         host.start(1'b0);
         settle();
         rchk(UCP_ADDR_CTRL, cw(tg, 1'b1, 2'h0));
         host.finish(1'b0, rx, mm);
         if (!(rx && mm)) tg = ~tg;
         settle();
         rchk(UCP_ADDR_CTRL, cw(tg, 1'b0, 2'h0));
      end
      wrr(UCP_ADDR_CTRL, 16'h0004);
      chk(16'(done_en), 16'h1);
      rchk(UCP_ADDR_CTRL, cw(tg, 1'b0, 2'h0));
      host.start(1'b1);
      host.finish(1'b1, 1'b1, 1'b0);
      settle();
      rchk(UCP_ADDR_CTRL, cw(tg, 1'b0, 2'h0));
      chk(16'(done_en), 16'h0);
      wrr(UCP_ADDR_CTRL, 16'h0105);
      host.pulse(0);
      settle();
      chk({rsel, valid, done_en, tog}, 5'b00101);
      wrr(UCP_ADDR_CTRL, 16'h0005);
      chk({rsel, done_en}, 3'b000);
      host.pulse(4);
      settle();
      chk(16'(valid), 16'h0);
      // Oversize is ignored under NAK, STALL only from BUF
      for (int k = 0; k < 4; k++) begin
         wrr(UCP_ADDR_CTRL, 16'(k != 0));
         host.pulse(k < 2 ? 1 : k);
         settle();
         chk(16'(rsel), k == 0 ? 16'h0 : k == 3 ? 16'h0 : 16'h3);
      end
      for (int k = 0; k < 2; k++) begin
         wrr(UCP_ADDR_CONFIG, k ? 16'h0080 : 16'h0000);
         wrr(UCP_ADDR_CTRL, 16'h0001);
         host.start(1'b0);
         host.finish(1'b0, 1'b1, 1'b0);
         settle();
         chk(16'(rsel), k ? 16'h0 : 16'h1);
      end
      final_report();
   end
endmodule
